// ---- src/node_address_decoder.sv ----
`timescale 1ns/10ps
`default_nettype none
module node_address_decoder
  import node_decoder_pkg::*;
#(
  parameter int NUM_CHIPS = MAX_CHIPS
)(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic [STRAP_W-1:0]   chip_node_number_strap_i,
  input  wire logic                 req_valid_i,
  input  wire req_t                 req_i,
  output var  logic                 resp_valid_o,
  output var  resp_t                resp_o,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [WB_ADDR_W-1:0] adr_i,
  input  wire logic [WB_SEL_W-1:0]  sel_i,
  input  wire logic [WB_DATA_W-1:0] dat_i,
  output var  logic [WB_DATA_W-1:0] dat_o,
  output var  logic                 ack_o
);

  if (NUM_CHIPS < 1 || NUM_CHIPS > MAX_CHIPS) begin : g_chk
    $error("NUM_CHIPS must lie between 1 and 4");
  end

  localparam logic [NODE_W-1:0] LAST_NODE = NODE_W'(NUM_CHIPS - 1);

  logic [STRAP_W-1:0]   strap_meta_q;
  logic [STRAP_W-1:0]   strap_sync_q;
  logic [SEL_W-1:0]     slice_sel_q;
  logic [NUM_PORTS-1:0] port_present_q;
  logic                 multi_chip_q;
  logic [COUNT_W-1:0]   refused_count_q;
  logic [ADDR_W-1:0]    refused_addr_q;
  logic                 ack_q;
  logic [WB_DATA_W-1:0] rdata_q;
  logic                 resp_valid_q;
  resp_t                resp_q;

  logic                 bus_req;
  logic                 bus_wr;
  logic [WB_DATA_W-1:0] rdata_d;
  logic [NODE_W-1:0]    local_node;
  logic [NODE_W-1:0]    req_node;
  logic [PORT_W-1:0]    req_port;
  logic [SLICE_W-1:0]   req_slice;
  resp_t                resp_d;

  // The strap is a pin and crosses two flip-flops before use.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_meta_q <= STRAP_RST;
      strap_sync_q <= STRAP_RST;
    end else if (ce_i) begin
      strap_meta_q <= chip_node_number_strap_i;
      strap_sync_q <= strap_meta_q;
    end
  end

  // A single chip answers as node 0 whatever its strap says.
  always_comb begin
    local_node = '0;
    if (multi_chip_q) begin
      local_node = {{(NODE_W-STRAP_W){1'b0}}, strap_sync_q};
    end
  end

  assign req_node = req_i.addr[NODE_LSB +: NODE_W];
  assign req_port = req_i.addr[PORT_LSB +: PORT_W];

  cache_slice_bit_select u_slice (
    .addr_i  (req_i.addr),
    .sel_i   (slice_sel_q),
    .slice_o (req_slice)
  );

  always_comb begin
    resp_d           = '0;
    resp_d.node      = req_node;
    resp_d.coherent  = (req_i.source != SRC_PBUS);
    if (req_node != local_node) begin
      if (multi_chip_q && req_node <= LAST_NODE) begin
        resp_d.target = TGT_REMOTE_NODE;
      end else begin
        resp_d.target = TGT_RESERVED;
        resp_d.error  = 1'b1;
      end
    end else if (!req_i.addr[HALF_BIT]) begin
      resp_d.target = TGT_SHARED_CACHE;
      resp_d.slice  = req_slice;
    end else if (port_present_q[req_port]) begin
      resp_d.target    = TGT_LINK_PORT;
      resp_d.port      = req_port;
      resp_d.link_ctrl = req_i.addr[LINK_SEL_BIT];
    end else begin
      resp_d.target = TGT_RESERVED;
      resp_d.port   = req_port;
      resp_d.error  = 1'b1;
    end
  end

  // The answer follows the request by exactly one clock.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_valid_q <= 1'b0;
      resp_q       <= '0;
    end else if (ce_i) begin
      resp_valid_q <= req_valid_i;
      if (req_valid_i) begin
        resp_q <= resp_d;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused_count_q <= '0;
      refused_addr_q  <= '0;
    end else if (ce_i && req_valid_i && resp_d.error) begin
      refused_addr_q <= req_i.addr;
      if (refused_count_q != {COUNT_W{1'b1}}) begin
        refused_count_q <= refused_count_q + COUNT_W'(1);
      end
    end
  end

  assign bus_req = cyc_i && stb_i && !ack_q;
  assign bus_wr  = bus_req && we_i && sel_i[0];

  // Software may change the bit pair while traffic is flowing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slice_sel_q <= SLICE_SEL_RST;
    end else if (ce_i && bus_wr && adr_i == SLICE_SEL_ADDR) begin
      slice_sel_q <= dat_i[SEL_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_present_q <= PORT_PRESENT_RST;
      multi_chip_q   <= MULTI_CHIP_RST;
    end else if (ce_i && bus_wr && adr_i == CONTROL_ADDR) begin
      port_present_q <= dat_i[CTRL_PRESENT_LSB +: NUM_PORTS];
      multi_chip_q   <= dat_i[CTRL_MULTI_BIT];
    end
  end

  always_comb begin
    rdata_d = '0;
    if (adr_i == SLICE_SEL_ADDR) begin
      rdata_d[SEL_W-1:0] = slice_sel_q;
    end else if (adr_i == CONTROL_ADDR) begin
      rdata_d[CTRL_PRESENT_LSB +: NUM_PORTS] = port_present_q;
      rdata_d[CTRL_MULTI_BIT]                = multi_chip_q;
    end else if (adr_i == STATUS_ADDR) begin
      rdata_d[STAT_NODE_LSB +: STRAP_W]  = strap_sync_q;
      rdata_d[STAT_COUNT_LSB +: COUNT_W] = refused_count_q;
    end else if (adr_i == REFUSED_LO_ADDR) begin
      rdata_d = refused_addr_q[ADDR_LO_W-1:0];
    end else if (adr_i == REFUSED_HI_ADDR) begin
      rdata_d[ADDR_HI_W-1:0] = refused_addr_q[ADDR_W-1:ADDR_LO_W];
    end
  end

  // Unmapped addresses are acknowledged, read as zero, and drop writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else if (ce_i) begin
      ack_q <= bus_req;
      if (bus_req && !we_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign resp_valid_o = resp_valid_q;
  assign resp_o       = resp_q;
  assign ack_o        = ack_q;
  assign dat_o        = rdata_q;

endmodule : node_address_decoder
`default_nettype wire

// ---- src/node_decoder_pkg.sv ----
package node_decoder_pkg;

  localparam int ADDR_W         = 48;
  localparam int NODE_W         = 4;
  localparam int STRAP_W        = 2;
  localparam int SLICE_W        = 2;
  localparam int SEL_W          = 4;
  localparam int PORT_W         = 2;
  localparam int NUM_PORTS      = 4;
  localparam int NUM_SEL        = 16;
  localparam int MAX_CHIPS      = 4;

  localparam int NODE_LSB       = 44;
  localparam int HALF_BIT       = 43;
  localparam int PORT_LSB       = 42;
  localparam int LINK_SEL_BIT   = 41;
  localparam int SLICE_BASE_BIT = 6;
  localparam int SLICE_STEP     = 2;

  localparam int WB_ADDR_W      = 32;
  localparam int WB_DATA_W      = 32;
  localparam int WB_SEL_W       = 4;
  localparam int COUNT_W        = 16;
  localparam int ADDR_LO_W      = 32;
  localparam int ADDR_HI_W      = 16;

  localparam logic [WB_ADDR_W-1:0] SLICE_SEL_ADDR  = 32'h3FF0_0400;
  localparam logic [WB_ADDR_W-1:0] CONTROL_ADDR    = 32'h3FF0_0404;
  localparam logic [WB_ADDR_W-1:0] STATUS_ADDR     = 32'h3FF0_0408;
  localparam logic [WB_ADDR_W-1:0] REFUSED_LO_ADDR = 32'h3FF0_040C;
  localparam logic [WB_ADDR_W-1:0] REFUSED_HI_ADDR = 32'h3FF0_0410;

  localparam int CTRL_PRESENT_LSB = 0;
  localparam int CTRL_MULTI_BIT   = 4;
  localparam int STAT_NODE_LSB    = 0;
  localparam int STAT_COUNT_LSB   = 16;

  localparam logic [SEL_W-1:0]     SLICE_SEL_RST    = 4'h0;
  localparam logic [NUM_PORTS-1:0] PORT_PRESENT_RST = 4'h8;
  localparam logic                 MULTI_CHIP_RST   = 1'b0;
  localparam logic [STRAP_W-1:0]   STRAP_RST        = 2'h0;

  typedef enum logic [1:0] {
    SRC_CORE = 2'b00,
    SRC_LINK = 2'b01,
    SRC_PBUS = 2'b10
  } req_source_t;

  typedef enum logic [2:0] {
    TGT_NONE         = 3'b000,
    TGT_SHARED_CACHE = 3'b001,
    TGT_LINK_PORT    = 3'b010,
    TGT_REMOTE_NODE  = 3'b011,
    TGT_RESERVED     = 3'b100
  } target_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    req_source_t       source;
  } req_t;

  typedef struct packed {
    logic [NODE_W-1:0]  node;
    target_t            target;
    logic [PORT_W-1:0]  port;
    logic               link_ctrl;
    logic [SLICE_W-1:0] slice;
    logic               coherent;
    logic               error;
  } resp_t;

endpackage : node_decoder_pkg

// ---- src/cache_slice_bit_select.sv ----
`timescale 1ns/10ps
`default_nettype none
module cache_slice_bit_select
  import node_decoder_pkg::*;
(
  input  wire logic [ADDR_W-1:0]  addr_i,
  input  wire logic [SEL_W-1:0]   sel_i,
  output var  logic [SLICE_W-1:0] slice_o
);

  logic [SLICE_W-1:0] cand [NUM_SEL];

  // Candidate g is the bit pair [2g+7:2g+6].
  for (genvar g = 0; g < NUM_SEL; g++) begin : g_cand
    assign cand[g] = addr_i[SLICE_BASE_BIT + SLICE_STEP*g +: SLICE_W];
  end

  always_comb begin
    slice_o = cand[sel_i];
  end

endmodule : cache_slice_bit_select
`default_nettype wire

// ---- tb/node_address_checker_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module node_address_checker
  import node_decoder_pkg::*;
(
  input wire logic  clk_i,
  input wire logic  rst_i,
  input wire logic  ce_i,
  input wire logic  req_valid_i,
  input wire req_t  req_i,
  input wire logic  resp_valid_o,
  input wire resp_t resp_o,
  input wire logic  cyc_i,
  input wire logic  stb_i,
  input wire logic  ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic tk = ce_i && req_valid_i;
  property p_lat; tk |=> resp_valid_o; endproperty
  a_lat: assert property (p_lat) else $error("response missing");
  property p_one; ce_i && !req_valid_i |=> !resp_valid_o; endproperty
  a_one: assert property (p_one) else $error("response without request");
  property p_hold; ce_i && !req_valid_i |=> $stable(resp_o); endproperty
  a_hold: assert property (p_hold) else $error("response changed");
  property p_node; tk |=> resp_o.node == $past(req_i.addr[47:44]); endproperty
  a_node: assert property (p_node) else $error("node wrong");
  property p_half; tk && req_i.addr[43] |=> resp_o.target != TGT_SHARED_CACHE; endproperty
  a_half: assert property (p_half) else $error("upper half to cache");
  property p_port;
    tk |=> resp_o.target == TGT_LINK_PORT |->
      resp_o.port == $past(req_i.addr[43:42]) && resp_o.link_ctrl == $past(req_i.addr[41]);
  endproperty
  a_port: assert property (p_port) else $error("port wrong");
  property p_err; resp_valid_o |-> resp_o.error == (resp_o.target == TGT_RESERVED); endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_coh; tk |=> resp_o.coherent == ($past(req_i.source) != SRC_PBUS); endproperty
  a_coh: assert property (p_coh) else $error("coherent flag wrong");
  property p_ack; ce_i && cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack late");
  property p_ackp; ack_o && ce_i |=> !ack_o; endproperty
  a_ackp: assert property (p_ackp) else $error("bus ack too long");
  c_err: cover property (resp_valid_o && resp_o.error);
  c_link: cover property (resp_valid_o && resp_o.target == TGT_LINK_PORT);
  c_ack: cover property (ack_o);
endmodule : node_address_checker
bind node_address_decoder node_address_checker node_address_checker_i (.*);
`default_nettype wire

// ---- tb/core_requester.sv ----
`timescale 1ns/10ps
`default_nettype none
module core_requester
  import node_decoder_pkg::*;
(
  input  wire logic clk_i,
  output var  logic req_valid_o,
  output var  req_t req_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  task automatic send(input logic [ADDR_W-1:0] a, input req_source_t s);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o <= '{addr: a, source: s};
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    // Released lines show the inverse so a stale decode cannot pass.
    req_o <= req_t'(~req_o);
  endtask : send
endmodule : core_requester
`default_nettype wire

// ---- tb/node_address_decoder_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module node_address_decoder_tb
  import node_decoder_pkg::*;
;
  logic                 clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [STRAP_W-1:0]   strap = 2'h2;
  logic [WB_ADDR_W-1:0] adr_i = '0;
  logic [WB_SEL_W-1:0]  sel_i = '0;
  logic [WB_DATA_W-1:0] dat_i = '0, dat_o, rd;
  logic                 req_valid_i, resp_valid_o, ack_o;
  req_t                 req_i;
  resp_t                resp_o;
  int                   n_errors = 0, check_count = 0;
  node_address_decoder #(.NUM_CHIPS(4)) node_address_decoder_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .chip_node_number_strap_i(strap),
    .req_valid_i(req_valid_i), .req_i(req_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
  core_requester core_requester_i (.clk_i(clk_i), .req_valid_o(req_valid_i), .req_o(req_i));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic end_sim();
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic dec(input logic [47:0] a, input req_source_t s, input target_t t);
    core_requester_i.send(a, s);
    #1;
    chk("resp_valid", resp_valid_o, 1'b1);
    chk("target", resp_o.target, t);
    chk("node", resp_o.node, a[47:44]);
    chk("error", resp_o.error, t == TGT_RESERVED);
  endtask : dec
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, SLICE_SEL_ADDR, 0);
    chk("sel_reset", rd, 32'h0);
    wb(0, CONTROL_ADDR, 0);
    chk("ctrl_reset", rd, 32'h8);
    wb(0, 32'h3FF0_0500, 0);
    chk("unmapped", rd, 32'h0);
    dec(48'h0000_0000_0080, SRC_CORE, TGT_SHARED_CACHE);
    chk("slice_reset", resp_o.slice, 2'h2);
    for (int k = 0; k < NUM_SEL; k++) begin
      wb(1, SLICE_SEL_ADDR, k);
      wb(0, SLICE_SEL_ADDR, 0);
      chk("sel_read", rd, k);
      dec(48'(k % 3 + 1) << (2 * k + 6), SRC_LINK, TGT_SHARED_CACHE);
      chk("slice", resp_o.slice, k % 3 + 1);
    end
    dec(48'h0E00_0000_0000, SRC_CORE, TGT_LINK_PORT);
    chk("ctrl_one", resp_o.link_ctrl, 1'b1);
    chk("port", resp_o.port, 2'h3);
    dec(48'h0C00_0000_0000, SRC_PBUS, TGT_LINK_PORT);
    chk("ctrl_zero", resp_o.link_ctrl, 1'b0);
    chk("coherent", resp_o.coherent, 1'b0);
    dec(48'h0800_0000_0000, SRC_CORE, TGT_RESERVED);
    dec(48'h1000_0000_0000, SRC_CORE, TGT_RESERVED);
    wb(0, STATUS_ADDR, 0);
    chk("status", rd, 32'h0002_0002);
    wb(0, REFUSED_HI_ADDR, 0);
    chk("refused_hi", rd, 32'h1000);
    wb(0, REFUSED_LO_ADDR, 0);
    chk("refused_lo", rd, 32'h0);
    wb(1, CONTROL_ADDR, 32'h18);
    dec(48'h2000_0000_0000, SRC_CORE, TGT_SHARED_CACHE);
    dec(48'h1000_0000_0000, SRC_CORE, TGT_REMOTE_NODE);
    dec(48'h5000_0000_0000, SRC_CORE, TGT_RESERVED);
    @(posedge clk_i);
    ce_i <= 1'b0;
    core_requester_i.send(48'h0000_0000_0040, SRC_CORE);
    #1;
    chk("ce_freeze", resp_valid_o, 1'b0);
    @(posedge clk_i);
    ce_i  <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, CONTROL_ADDR, 0);
    chk("ctrl_rerst", rd, 32'h8);
    wb(0, SLICE_SEL_ADDR, 0);
    chk("sel_rerst", rd, 32'h0);
    end_sim();
  end
endmodule : node_address_decoder_tb
`default_nettype wire
